// ---- logic/otp_shadow_pkg.sv ----
// constants for the otp, identification and register shadow block
// Behaviour
// - 9Fh reads read-only identification space
// - 5Ah reads read-only discoverable-parameter space
// - identification space also mapped inside parameter space
// - 1024-byte otp, 32 lockable 32-byte regions
// - random bytes 000-00F; programming ones ignored
// - zero into random bytes fails, sets error
// - bytes 010-013 hold region locks, 0 locks
// - locked region refuses programming; locks ship erased
// - reserved bytes 014-01F remain programmable
// - all other otp bytes ship as FF
// - lockdown bit refuses all otp programming until reset
// - registers reached only by dedicated commands
// - paired register reads return the copy at the address read; protect mode reads the live copy
// - reset copies persistent registers into live copies
// - persistent write: erase, program, refresh live
// - otp register program updates matching live bits
// - live write leaves persistent copy untouched
// - unpaired live status2 defaults on reset; persistent bits kept
// - program error flag is live status bit 6
package otp_shadow_pkg;
	// command codes
	localparam logic [7:0] CMD_ID_READ = 8'h9f;
	localparam logic [7:0] CMD_PARAM_READ = 8'h5a;
	localparam logic [7:0] CMD_OTP_READ = 8'h4b;
	localparam logic [7:0] CMD_OTP_PROG = 8'h42;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_REG_READ = 8'h65;
	localparam logic [7:0] CMD_REG_WRITE = 8'h71;
	localparam logic [7:0] CMD_WRITE_EN = 8'h06;
	localparam logic [7:0] CMD_WRITE_DIS = 8'h04;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hf0;
	// otp layout
	localparam int OTP_SIZE = 1024;
	localparam logic [9:0] RAND_BYTES = 10'h010;
	localparam logic [9:0] LOCK_BASE = 10'h010;
	localparam logic [9:0] RSVD_BASE = 10'h014;
	localparam int REGION_SHIFT = 5;
	localparam logic [7:0] ERASED = 8'hff;
	// identification space and its place in the parameter space
	localparam logic [23:0] ID_LEN = 24'h000010;
	localparam logic [23:0] PARAM_HDR_LEN = 24'h000010;
	localparam logic [23:0] PARAM_ID_BASE = 24'h000010;
	// register command addresses and shadow pairs
	localparam int REG_PAIRS = 6;
	localparam int IDX_STATUS1 = 0;
	localparam int IDX_CONFIG1 = 1;
	localparam logic [23:0] REG_PERSIST_BASE = 24'h000000;
	localparam logic [23:0] REG_LIVE_BASE = 24'h800000;
	localparam logic [23:0] REG_STATUS2_LIVE = 24'h800006;
	localparam logic [23:0] REG_ECC_STATUS = 24'h800007;
	localparam logic [23:0] REG_PROTECT_MODE_LO = 24'h000020;
	localparam logic [23:0] REG_PROTECT_MODE_HI = 24'h000021;
	// field positions
	localparam int BIT_PROG_ERR = 6;
	localparam int BIT_ERASE_ERR = 5;
	localparam int BIT_WRITE_EN = 1;
	localparam int BIT_LOCKDOWN = 0;
	// write masks
	localparam logic [7:0] STATUS1_PERSIST_MASK = 8'h9c;
	localparam logic [7:0] STATUS1_LIVE_MASK = 8'h1c;
	localparam logic [7:0] CONFIG1_PERSIST_MASK = 8'hfe;
	localparam logic [7:0] PERSIST_MASK = 8'hff;
	localparam logic [7:0] PROTECT_MODE_LO_MASK = 8'hfe;
	// delivered and reset values
	localparam logic [7:0] PERSIST_DELIVERED = 8'h00;
	localparam logic [15:0] PROTECT_MODE_DELIVERED = 16'hffff;
	localparam logic [7:0] STATUS2_RESET = 8'h00;
	localparam logic [7:0] ECC_STATUS_RESET = 8'h00;

	typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_READ, PH_PROG, PH_WDATA, PH_IGNORE} phase_t;
endpackage

// ---- logic/otp_shadow.sv ----
// serial flash otp space, identification spaces and register shadow copies
`timescale 1ns/1ns
module otp_shadow #(
	parameter int OTP_BYTES = otp_shadow_pkg::OTP_SIZE,
	// factory content; values are arbitrary
	parameter logic [127:0] RANDOM_VALUE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0,
	parameter logic [127:0] ID_CONTENT = 128'h00000000000000000000000000a5a5a5,
	parameter logic [127:0] PARAM_HEADER = 128'h000000000000000000000000000100aa
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n
);
	typedef struct packed {
		logic sck_a, sck_b, sck_c;
		logic cs_a, cs_b, cs_c;
		logic mosi_a, mosi_b;
		otp_shadow_pkg::phase_t ph;
		logic [7:0] cmd;
		logic [6:0] rx;
		logic [2:0] bit_cnt;
		logic [1:0] acnt;
		logic [23:0] addr;
		logic [7:0] tx;
		logic miso;
		logic drive;
		logic [OTP_BYTES-1:0][7:0] otp;
		logic [otp_shadow_pkg::REG_PAIRS-1:0][7:0] persist;
		logic [otp_shadow_pkg::REG_PAIRS-1:0][7:0] live;
		logic [7:0] status2;
		logic [15:0] protect_nv;
		logic [15:0] protect_live;
	} state_t;

	localparam logic [OTP_BYTES*8-1:0] OTP_DELIVERED = {{((OTP_BYTES-16)*8){1'b1}}, RANDOM_VALUE};

	state_t r_r, r_nxt;
	// event strobes, also watched by the checks below
	logic ev_soft_reset;
	logic ev_persist_wr;
	logic ev_live_wr;
	logic ev_prog;
	logic [2:0] wr_idx;
	// a data byte with any zero bit, for the random-byte check
	logic b_has_zero;

	function automatic logic [7:0] id_byte(input logic [23:0] a);
		return (a < otp_shadow_pkg::ID_LEN) ? 8'(ID_CONTENT >> {a[3:0], 3'b000}) : otp_shadow_pkg::ERASED;
	endfunction

	function automatic logic [7:0] param_byte(input logic [23:0] a);
		logic [23:0] off;
		off = a - otp_shadow_pkg::PARAM_ID_BASE;
		if (a < otp_shadow_pkg::PARAM_HDR_LEN) begin
			return 8'(PARAM_HEADER >> {a[3:0], 3'b000});
		end
		if (a >= otp_shadow_pkg::PARAM_ID_BASE && off < otp_shadow_pkg::ID_LEN) begin
			return id_byte(off);
		end
		return otp_shadow_pkg::ERASED;
	endfunction

	// register space is reached only by the register commands, never by array reads
	function automatic logic [7:0] reg_byte(input state_t s, input logic [23:0] a);
		logic [7:0] v;
		v = otp_shadow_pkg::ERASED;
		for (int i = 0; i < otp_shadow_pkg::REG_PAIRS; i++) begin
			if (a == otp_shadow_pkg::REG_PERSIST_BASE + 24'(i)) begin
				v = s.persist[i];
			end
			if (a == otp_shadow_pkg::REG_LIVE_BASE + 24'(i)) begin
				v = s.live[i];
			end
		end
		if (a == otp_shadow_pkg::REG_STATUS2_LIVE) begin
			v = s.status2;
		end
		if (a == otp_shadow_pkg::REG_ECC_STATUS) begin
			v = otp_shadow_pkg::ECC_STATUS_RESET;
		end
		if (a == otp_shadow_pkg::REG_PROTECT_MODE_LO) begin
			v = s.protect_live[7:0];
		end
		if (a == otp_shadow_pkg::REG_PROTECT_MODE_HI) begin
			v = s.protect_live[15:8];
		end
		return v;
	endfunction

	function automatic logic [7:0] read_byte(input state_t s, input logic [23:0] a);
		logic [7:0] v;
		v = otp_shadow_pkg::ERASED;
		unique case (s.cmd)
			otp_shadow_pkg::CMD_ID_READ: v = id_byte(a);
			otp_shadow_pkg::CMD_PARAM_READ: v = param_byte(a);
			otp_shadow_pkg::CMD_OTP_READ: v = (a < 24'(OTP_BYTES)) ? s.otp[a[9:0]] : otp_shadow_pkg::ERASED;
			otp_shadow_pkg::CMD_REG_READ: v = reg_byte(s, a);
			otp_shadow_pkg::CMD_STATUS_READ: v = s.live[otp_shadow_pkg::IDX_STATUS1];
			default: v = otp_shadow_pkg::ERASED;
		endcase
		return v;
	endfunction

	function automatic logic [7:0] persist_mask(input int i);
		if (i == otp_shadow_pkg::IDX_STATUS1) begin
			return otp_shadow_pkg::STATUS1_PERSIST_MASK;
		end
		if (i == otp_shadow_pkg::IDX_CONFIG1) begin
			return otp_shadow_pkg::CONFIG1_PERSIST_MASK;
		end
		return otp_shadow_pkg::PERSIST_MASK;
	endfunction

	always_comb begin
		logic sck_rise;
		logic sck_fall;
		logic byte_done;
		logic [7:0] b;
		logic [23:0] a_new;
		logic [9:0] oa;
		logic [4:0] region;
		logic [9:0] lock_at;
		logic [7:0] m;
		logic [7:0] nv_new;
		// edges come from the second and third flops; the first one is never read by logic
		sck_rise = r_r.sck_b & ~r_r.sck_c;
		sck_fall = ~r_r.sck_b & r_r.sck_c;
		byte_done = 1'b0;
		b = {r_r.rx, r_r.mosi_b};
		a_new = {r_r.addr[15:0], b};
		oa = r_r.addr[9:0];
		region = oa[9:5];
		lock_at = otp_shadow_pkg::LOCK_BASE + 10'(region[4:3]);
		m = '0;
		nv_new = '0;
		ev_soft_reset = 1'b0;
		ev_persist_wr = 1'b0;
		ev_live_wr = 1'b0;
		ev_prog = 1'b0;
		wr_idx = '0;
		r_nxt = r_r;
		// pins cross in from the link side
		r_nxt.sck_a = sck;
		r_nxt.sck_b = r_r.sck_a;
		r_nxt.sck_c = r_r.sck_b;
		r_nxt.cs_a = cs_n;
		r_nxt.cs_b = r_r.cs_a;
		r_nxt.cs_c = r_r.cs_b;
		r_nxt.mosi_a = mosi;
		r_nxt.mosi_b = r_r.mosi_a;
		if (r_r.cs_b) begin
			// write enable is consumed by a program or write frame
			// a register write has already left its data phase, so go by the command
			if (~r_r.cs_c && r_r.ph != otp_shadow_pkg::PH_CMD &&
				(r_r.cmd == otp_shadow_pkg::CMD_OTP_PROG || r_r.cmd == otp_shadow_pkg::CMD_REG_WRITE)) begin
				r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_WRITE_EN] = 1'b0;
			end
			r_nxt.ph = otp_shadow_pkg::PH_CMD;
			r_nxt.bit_cnt = '0;
			r_nxt.drive = 1'b0;
		end else begin
			r_nxt.drive = 1'b1;
			if (sck_fall) begin
				r_nxt.miso = r_r.tx[7];
				r_nxt.tx = {r_r.tx[6:0], 1'b1};
			end
			if (sck_rise) begin
				r_nxt.rx = b[6:0];
				r_nxt.bit_cnt = r_r.bit_cnt + 3'd1;
				byte_done = (r_r.bit_cnt == 3'd7);
			end
		end
		if (byte_done) begin
			unique case (r_r.ph)
				otp_shadow_pkg::PH_CMD: begin
					r_nxt.cmd = b;
					r_nxt.acnt = '0;
					r_nxt.addr = '0;
					r_nxt.ph = otp_shadow_pkg::PH_IGNORE;
					unique case (b)
						otp_shadow_pkg::CMD_ID_READ: begin
							r_nxt.ph = otp_shadow_pkg::PH_READ;
							r_nxt.addr = 24'h000001;
							r_nxt.tx = id_byte('0);
						end
						otp_shadow_pkg::CMD_STATUS_READ: begin
							r_nxt.ph = otp_shadow_pkg::PH_READ;
							r_nxt.tx = r_r.live[otp_shadow_pkg::IDX_STATUS1];
						end
						otp_shadow_pkg::CMD_PARAM_READ,
						otp_shadow_pkg::CMD_OTP_READ,
						otp_shadow_pkg::CMD_REG_READ: r_nxt.ph = otp_shadow_pkg::PH_ADDR;
						otp_shadow_pkg::CMD_OTP_PROG,
						otp_shadow_pkg::CMD_REG_WRITE: begin
							if (r_r.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_WRITE_EN]) begin
								r_nxt.ph = otp_shadow_pkg::PH_ADDR;
							end
						end
						otp_shadow_pkg::CMD_WRITE_EN:
							r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_WRITE_EN] = 1'b1;
						otp_shadow_pkg::CMD_WRITE_DIS:
							r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_WRITE_EN] = 1'b0;
						otp_shadow_pkg::CMD_CLEAR_STATUS: begin
							r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_PROG_ERR] = 1'b0;
							r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_ERASE_ERR] = 1'b0;
						end
						otp_shadow_pkg::CMD_SOFT_RESET: begin
							// persistent copies and the otp array are kept
							ev_soft_reset = 1'b1;
							r_nxt.live = r_r.persist;
							r_nxt.protect_live = r_r.protect_nv;
							r_nxt.status2 = otp_shadow_pkg::STATUS2_RESET;
						end
						default: r_nxt.ph = otp_shadow_pkg::PH_IGNORE;
					endcase
				end
				otp_shadow_pkg::PH_ADDR: begin
					r_nxt.addr = a_new;
					r_nxt.acnt = r_r.acnt + 2'd1;
					if (r_r.acnt == 2'd2) begin
						if (r_r.cmd == otp_shadow_pkg::CMD_OTP_PROG) begin
							r_nxt.ph = otp_shadow_pkg::PH_PROG;
						end else if (r_r.cmd == otp_shadow_pkg::CMD_REG_WRITE) begin
							r_nxt.ph = otp_shadow_pkg::PH_WDATA;
						end else begin
							r_nxt.ph = otp_shadow_pkg::PH_DUMMY;
						end
					end
				end
				otp_shadow_pkg::PH_DUMMY,
				otp_shadow_pkg::PH_READ: begin
					r_nxt.ph = otp_shadow_pkg::PH_READ;
					r_nxt.tx = read_byte(r_r, r_r.addr);
					r_nxt.addr = r_r.addr + 24'h000001;
				end
				otp_shadow_pkg::PH_PROG: begin
					ev_prog = 1'b1;
					r_nxt.addr = r_r.addr + 24'h000001;
					if (r_r.addr >= 24'(OTP_BYTES)) begin
						r_nxt.addr = r_r.addr;
					end else if (r_r.live[otp_shadow_pkg::IDX_CONFIG1][otp_shadow_pkg::BIT_LOCKDOWN]) begin
						r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_PROG_ERR] = 1'b1;
					end else if (oa < otp_shadow_pkg::RAND_BYTES) begin
						// ones are ignored, any zero is an error
						if (b != otp_shadow_pkg::ERASED) begin
							r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_PROG_ERR] = 1'b1;
						end
					end else if (!r_r.otp[lock_at][region[2:0]]) begin
						r_nxt.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_PROG_ERR] = 1'b1;
					end else begin
						// lock and reserved bytes go through the same path
						r_nxt.otp[oa] = r_r.otp[oa] & b;
					end
				end
				otp_shadow_pkg::PH_WDATA: begin
					r_nxt.ph = otp_shadow_pkg::PH_IGNORE;
					for (int i = 0; i < otp_shadow_pkg::REG_PAIRS; i++) begin
						if (r_r.addr == otp_shadow_pkg::REG_PERSIST_BASE + 24'(i)) begin
							// erase then program the writable bits, then refresh the live copy
							m = persist_mask(i);
							nv_new = (r_r.persist[i] & ~m) | (b & m);
							r_nxt.persist[i] = nv_new;
							r_nxt.live[i] = (r_r.live[i] & ~m) | (nv_new & m);
							ev_persist_wr = 1'b1;
							wr_idx = 3'(i);
						end
						if (r_r.addr == otp_shadow_pkg::REG_LIVE_BASE + 24'(i)) begin
							m = (i == otp_shadow_pkg::IDX_STATUS1) ? otp_shadow_pkg::STATUS1_LIVE_MASK : 8'hff;
							r_nxt.live[i] = (r_r.live[i] & ~m) | (b & m);
							ev_live_wr = 1'b1;
							wr_idx = 3'(i);
						end
					end
					// the lockdown bit cannot be cleared by a write
					r_nxt.live[otp_shadow_pkg::IDX_CONFIG1][otp_shadow_pkg::BIT_LOCKDOWN] =
						r_nxt.live[otp_shadow_pkg::IDX_CONFIG1][otp_shadow_pkg::BIT_LOCKDOWN] |
						r_r.live[otp_shadow_pkg::IDX_CONFIG1][otp_shadow_pkg::BIT_LOCKDOWN];
					if (r_r.addr == otp_shadow_pkg::REG_STATUS2_LIVE) begin
						r_nxt.status2 = b;
					end
					if (r_r.addr == otp_shadow_pkg::REG_PROTECT_MODE_LO) begin
						m = otp_shadow_pkg::PROTECT_MODE_LO_MASK;
						r_nxt.protect_nv[7:0] = r_r.protect_nv[7:0] & (b | ~m);
						r_nxt.protect_live[7:0] = r_r.protect_live[7:0] & (b | ~m);
					end
					if (r_r.addr == otp_shadow_pkg::REG_PROTECT_MODE_HI) begin
						r_nxt.protect_nv[15:8] = r_r.protect_nv[15:8] & b;
						r_nxt.protect_live[15:8] = r_r.protect_live[15:8] & b;
					end
				end
				default: r_nxt.ph = otp_shadow_pkg::PH_IGNORE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// power-on state: otp and persistent copies take their delivered contents
			r_r <= '0;
			r_r.sck_a <= 1'b0;
			r_r.cs_a <= 1'b1;
			r_r.cs_b <= 1'b1;
			r_r.cs_c <= 1'b1;
			r_r.ph <= otp_shadow_pkg::PH_CMD;
			r_r.tx <= otp_shadow_pkg::ERASED;
			r_r.otp <= OTP_DELIVERED;
			r_r.persist <= {otp_shadow_pkg::REG_PAIRS{otp_shadow_pkg::PERSIST_DELIVERED}};
			r_r.live <= {otp_shadow_pkg::REG_PAIRS{otp_shadow_pkg::PERSIST_DELIVERED}};
			r_r.status2 <= otp_shadow_pkg::STATUS2_RESET;
			r_r.protect_nv <= otp_shadow_pkg::PROTECT_MODE_DELIVERED;
			r_r.protect_live <= otp_shadow_pkg::PROTECT_MODE_DELIVERED;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign miso = r_r.miso;
	assign miso_oe_n = ~r_r.drive;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	property p_only_clears;
		##1 ((r_r.otp & ~$past(r_r.otp)) == '0);
	endproperty
	a_only_clears: assert property (p_only_clears) else $error("otp bit returned to one");

	property p_random_fixed;
		##1 $stable(r_r.otp[15:0]);
	endproperty
	a_random_fixed: assert property (p_random_fixed) else $error("random bytes changed");

	property p_lockdown_holds;
		r_r.live[otp_shadow_pkg::IDX_CONFIG1][otp_shadow_pkg::BIT_LOCKDOWN] && !ev_soft_reset |=>
			$stable(r_r.otp) && r_r.live[otp_shadow_pkg::IDX_CONFIG1][otp_shadow_pkg::BIT_LOCKDOWN];
	endproperty
	a_lockdown_holds: assert property (p_lockdown_holds) else $error("otp changed under lockdown");

	property p_random_zero_err;
		ev_prog && r_r.addr < 24'(otp_shadow_pkg::RAND_BYTES) && b_has_zero |=>
			r_r.live[otp_shadow_pkg::IDX_STATUS1][otp_shadow_pkg::BIT_PROG_ERR];
	endproperty
	a_random_zero_err: assert property (p_random_zero_err) else $error("zero into random bytes not flagged");

	assign b_has_zero = ({r_r.rx, r_r.mosi_b} != otp_shadow_pkg::ERASED);

	property p_locked_refused;
		ev_prog && r_r.addr >= 24'(otp_shadow_pkg::RAND_BYTES) && r_r.addr < 24'(OTP_BYTES) &&
			!r_r.otp[otp_shadow_pkg::LOCK_BASE + 10'(r_r.addr[9:8])][r_r.addr[7:5]] |=> $stable(r_r.otp);
	endproperty
	a_locked_refused: assert property (p_locked_refused) else $error("locked region was programmed");

	property p_soft_reset_copy;
		ev_soft_reset |=> (r_r.live == r_r.persist) && (r_r.protect_live == r_r.protect_nv);
	endproperty
	a_soft_reset_copy: assert property (p_soft_reset_copy) else $error("live copy not reloaded");

	property p_live_write_only;
		ev_live_wr |=> $stable(r_r.persist) && $stable(r_r.protect_nv);
	endproperty
	a_live_write_only: assert property (p_live_write_only) else $error("live write touched persistent copy");

	property p_persist_refresh;
		ev_persist_wr && wr_idx != 3'(otp_shadow_pkg::IDX_STATUS1) && wr_idx != 3'(otp_shadow_pkg::IDX_CONFIG1) |=>
			r_r.live[$past(wr_idx)] == r_r.persist[$past(wr_idx)];
	endproperty
	a_persist_refresh: assert property (p_persist_refresh) else $error("live copy not refreshed");
endmodule // otp_shadow

// ---- sim/spi_host_model.sv ----
// serial host model that frames commands toward the otp block
`timescale 1ns/1ns
module spi_host_model (
	// system clock
	input wire logic clock,
	// serial link
	output logic sck,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// eight clocks per sck phase, well past the device's two-flop sampling
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			tick(8);
			sck = 1'b1;
			rx[i] = miso;
			tick(8);
			sck = 1'b0;
		end
	endtask

	task automatic start();
		tick(1);
		cs_n = 1'b0;
		tick(4);
	endtask

	// released data line flips so a stale bit never looks driven
	task automatic stop();
		tick(2);
		cs_n = 1'b1;
		mosi = ~mosi;
		tick(6);
	endtask
endmodule // spi_host_model

// ---- sim/tb_otp_shadow.sv ----
// self-checking bench for the otp, identification and shadow register block
`timescale 1ns/1ns
module tb_otp_shadow;
	// factory contents; values are arbitrary
	localparam logic [127:0] RND = 128'h8877665544332211_f0e0d0c0b0a09080;
	localparam logic [127:0] IDC = 128'h0000000000000000_1234567890abcdef;
	localparam logic [127:0] PHDR = 128'h0000000000000000_0000000301020304;

	logic clock;
	logic arst_n;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe_n;
	int n_errors;
	int num_checks;

	otp_shadow #(.RANDOM_VALUE(RND), .ID_CONTENT(IDC), .PARAM_HEADER(PHDR)) dut (
		.clock(clock),
		.arst_n(arst_n),
		.sck(sck),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe_n(miso_oe_n)
	);

	spi_host_model host (
		.clock(clock),
		.sck(sck),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic put(input logic [7:0] b);
		logic [7:0] d;
		host.xfer(b, d);
	endtask

	task automatic addr_out(input logic [23:0] a);
		put(a[23:16]);
		put(a[15:8]);
		put(a[7:0]);
	endtask

	task automatic simple(input logic [7:0] c);
		host.start();
		put(c);
		host.stop();
	endtask

	// write enable frame when en is set, then command, address and one data byte
	task automatic wr(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d, input logic en);
		if (en) begin
			simple(otp_shadow_pkg::CMD_WRITE_EN);
		end
		host.start();
		put(c);
		addr_out(a);
		put(d);
		host.stop();
	endtask

	// expected bytes come from e, lowest byte first
	task automatic rd(input logic [7:0] c, input logic [23:0] a, input int n, input logic [127:0] e);
		logic [7:0] d;
		host.start();
		put(c);
		chk({7'h00, miso_oe_n}, 8'h00);
		if (c != otp_shadow_pkg::CMD_ID_READ && c != otp_shadow_pkg::CMD_STATUS_READ) begin
			addr_out(a);
			put(8'h00);
		end
		for (int i = 0; i < n; i++) begin
			host.xfer(8'hff, d);
			chk(d, e[8 * i +: 8]);
		end
		host.stop();
		chk({7'h00, miso_oe_n}, 8'h01);
	endtask

	task automatic prog(input logic [23:0] a, input logic [7:0] d);
		wr(otp_shadow_pkg::CMD_OTP_PROG, a, d, 1'b1);
	endtask

	task automatic rwr(input logic [23:0] a, input logic [7:0] d);
		wr(otp_shadow_pkg::CMD_REG_WRITE, a, d, 1'b1);
	endtask

	task automatic otp(input logic [23:0] a, input int n, input logic [127:0] e);
		rd(otp_shadow_pkg::CMD_OTP_READ, a, n, e);
	endtask

	task automatic reg1(input logic [23:0] a, input logic [7:0] e);
		rd(otp_shadow_pkg::CMD_REG_READ, a, 1, {120'h0, e});
	endtask

	task automatic stat(input logic [7:0] e);
		rd(otp_shadow_pkg::CMD_STATUS_READ, 24'h000000, 1, {120'h0, e});
	endtask

	// hang guard, well above the length of the full sequence
	initial begin
		repeat (90000) @(posedge clock);
		n_errors++;
		end_sim();
	end

	initial begin
		arst_n = 1'b0;
		n_errors = 0;
		num_checks = 0;
		repeat (6) @(posedge clock);
		#1;
		arst_n = 1'b1;
		repeat (3) @(posedge clock);

		stat(8'h00);
		otp(24'h000000, 16, RND);
		otp(24'h000010, 16, {128{1'b1}});
		otp(24'h0003ff, 1, 128'hff);
		$display("test delivered state done");

		rd(otp_shadow_pkg::CMD_ID_READ, 24'h000000, 16, IDC);
		rd(otp_shadow_pkg::CMD_PARAM_READ, 24'h000000, 16, PHDR);
		rd(otp_shadow_pkg::CMD_PARAM_READ, 24'h000010, 16, IDC);
		$display("test identification spaces done");

		prog(24'h000020, 8'h0f);
		otp(24'h000020, 1, 128'h0f);
		prog(24'h000020, 8'hf0);
		prog(24'h000020, 8'hff);
		otp(24'h000020, 1, 128'h00);
		$display("test clear-only programming done");

		prog(24'h000000, 8'hff);
		stat(8'h00);
		prog(24'h000001, 8'h00);
		stat(8'h40);
		otp(24'h000000, 16, RND);
		simple(otp_shadow_pkg::CMD_CLEAR_STATUS);
		stat(8'h00);
		$display("test random bytes done");

		prog(24'h000014, 8'h5a);
		otp(24'h000014, 1, 128'h5a);
		// bit 1 of the first lock byte guards region 1
		prog(24'h000010, 8'hfd);
		otp(24'h000010, 1, 128'hfd);
		prog(24'h000021, 8'h00);
		otp(24'h000021, 1, 128'hff);
		stat(8'h40);
		simple(otp_shadow_pkg::CMD_CLEAR_STATUS);
		wr(otp_shadow_pkg::CMD_OTP_PROG, 24'h000040, 8'h00, 1'b0);
		otp(24'h000040, 1, 128'hff);
		simple(otp_shadow_pkg::CMD_WRITE_EN);
		stat(8'h02);
		simple(otp_shadow_pkg::CMD_WRITE_DIS);
		stat(8'h00);
		$display("test region locks done");

		rwr(24'h800001, 8'h01);
		reg1(24'h800001, 8'h01);
		prog(24'h000040, 8'h00);
		otp(24'h000040, 1, 128'hff);
		stat(8'h40);
		simple(otp_shadow_pkg::CMD_SOFT_RESET);
		reg1(24'h800001, 8'h00);
		prog(24'h000040, 8'h3c);
		otp(24'h000040, 1, 128'h3c);
		$display("test lockdown done");

		rwr(24'h000001, 8'h04);
		reg1(24'h000001, 8'h04);
		reg1(24'h800001, 8'h04);
		rwr(24'h800001, 8'h08);
		stat(8'h00);
		reg1(24'h800001, 8'h08);
		reg1(24'h000001, 8'h04);
		rwr(24'h000002, 8'h5a);
		reg1(24'h800002, 8'h5a);
		simple(otp_shadow_pkg::CMD_SOFT_RESET);
		reg1(24'h800001, 8'h04);
		reg1(24'h800002, 8'h5a);
		reg1(24'h800006, 8'h00);
		reg1(24'h800007, 8'h00);
		rwr(24'h000020, 8'hf0);
		reg1(24'h000020, 8'hf1);
		rwr(24'h000020, 8'hff);
		reg1(24'h000020, 8'hf1);
		rwr(24'h000021, 8'h0f);
		reg1(24'h000021, 8'h0f);
		rwr(24'h000010, 8'h00);
		reg1(24'h000010, 8'hff);
		$display("test register shadows done");
		end_sim();
	end
endmodule // tb_otp_shadow
